// ===== verilog/sfcf_pkg.sv
`default_nettype none
package sfcf_pkg;
   // Command codes
   localparam logic [7:0] OP_WR_ENABLE  = 8'h06;
   localparam logic [7:0] OP_WR_DISABLE = 8'h04;
   localparam logic [7:0] OP_RD_SR1     = 8'h05;
   localparam logic [7:0] OP_RD_SR2     = 8'h35;
   localparam logic [7:0] OP_RD_SR3     = 8'h15;
   localparam logic [7:0] OP_WR_SR1     = 8'h01;
   localparam logic [7:0] OP_WR_SR2     = 8'h31;
   localparam logic [7:0] OP_WR_SR3     = 8'h11;
   localparam logic [7:0] OP_VOL_SR_EN  = 8'h50;
   localparam logic [7:0] OP_READ       = 8'h03;
   localparam logic [7:0] OP_FAST       = 8'h0B;
   localparam logic [7:0] OP_DUAL_OUT   = 8'h3B;
   localparam logic [7:0] OP_QUAD_OUT   = 8'h6B;
   localparam logic [7:0] OP_DUAL_IO    = 8'hBB;
   localparam logic [7:0] OP_QUAD_IO    = 8'hEB;
   localparam logic [7:0] OP_WRAP       = 8'h77;
   localparam logic [7:0] OP_PROG       = 8'h02;
   localparam logic [7:0] OP_SUSPEND    = 8'h75;
   localparam logic [7:0] OP_RESUME     = 8'h7A;
   localparam logic [7:0] OP_RST_ARM    = 8'h66;
   localparam logic [7:0] OP_RST_DO     = 8'h99;
   // Field positions within the 24-bit status word
   localparam int BUSY_BIT     = 0;
   localparam int WEL_BIT      = 1;
   localparam int BP_LO        = 2;
   localparam int SRP0_BIT     = 7;
   localparam int SRP1_BIT     = 8;
   localparam int QUAD_BIT     = 9;
   localparam int PPAUSE_BIT   = 10;
   localparam int LOCK_LO      = 11;
   localparam int INV_BIT      = 14;
   localparam int EPAUSE_BIT   = 15;
   localparam int DSEL_BIT     = 16;
   localparam int STRENGTH_LO  = 21;
   // Factory reset values
   localparam logic [1:0] STRENGTH_RST = 2'h1;
   localparam logic [4:0] BP_RST       = 5'h00;
   localparam logic [2:0] LOCK_RST     = 3'h0;
   // Frame timing in serial clocks
   localparam logic [15:0] OPCODE_CLKS     = 16'h0008;
   localparam logic [15:0] ADDR_BITS       = 16'h0018;
   localparam logic [15:0] MODE_BITS       = 16'h0008;
   localparam logic [15:0] FAST_DUMMY_CLKS = 16'h0008;
   localparam logic [15:0] DIO_DUMMY_LO    = 16'h0004;
   localparam logic [15:0] DIO_DUMMY_HI    = 16'h0008;
   localparam logic [15:0] QIO_DUMMY_LO    = 16'h0006;
   localparam logic [15:0] QIO_DUMMY_HI    = 16'h000A;
   localparam logic [15:0] WRAP_DUMMY_CLKS = 16'h0018;
   localparam logic [15:0] ONE_BYTE_CLKS   = 16'h0008;
   localparam logic [15:0] TWO_BYTE_CLKS   = 16'h0010;
   localparam logic [15:0] PROG_HDR_CLKS   = 16'h0020;
   localparam logic [15:0] PROG_MIN_CLKS   = 16'h0028;
   localparam logic [15:0] WRAP_CLKS       = 16'h0028;
   localparam logic [15:0] PAGE_BYTES      = 16'h0100;
endpackage
`default_nettype wire

// ===== verilog/sfcf_frontend.sv
// How it works
// - Three lock bits only ever go 0 to 1
// - Protect-invert bit stored and forwarded
// - Suspend sets erase or program paused flag
// - Resume, reset pair, power-up clear paused flags
// - Dual I/O read: 4 or 8 dummy clocks
// - Quad I/O read: 6 or 10 dummy clocks
// - Two-bit output strength stored, default 01
// - MSB first, inputs sampled on rising clock
// - Frame starts with one opcode byte
// - Reads stream until chip select rises
// - Write-type commands need whole-byte frames
// - Partial program byte: no program, latch kept
// - Status reads repeat the selected byte
// - Status writes take exactly one byte
// - 50H enables one volatile status write
// - 03H: three address bytes, no dummy
// - 0BH: address, one dummy byte, single line
// - 6BH quad out, 3BH dual out, dummy byte
// - BBH: address and mode on two lines
// - EBH: address and mode on four lines
// - 77H: three dummies then wrap byte
// - Write latch gates program, status write
// - Latch cleared by 04H, completion, power-up
// - Busy flag mirrors the array engine
// - Quad bit gates four-line commands
`timescale 1ns/1ps
`default_nettype none
module sfcf_frontend (
   input  wire logic        clk_i,
   input  wire logic        rst_b_i,
   input  wire logic        sclk_i,
   input  wire logic        cs_b_i,
   input  wire logic [3:0]  io_i,
   output logic      [3:0]  io_o,
   output logic      [3:0]  io_oe_o,
   output logic      [23:0] mem_addr_o,
   input  wire logic [7:0]  mem_rdata_i,
   input  wire logic        busy_i,
   input  wire logic        done_i,
   input  wire logic        erase_active_i,
   output logic             prog_req_o,
   output logic      [23:0] prog_addr_o,
   output logic      [8:0]  prog_len_o,
   input  wire logic [7:0]  buf_rd_idx_i,
   output logic      [7:0]  buf_rd_data_o,
   output logic             status_wr_req_o,
   output logic      [4:0]  block_protect_field_o,
   output logic             protect_invert_o,
   output logic      [2:0]  otp_lock_o,
   output logic             quad_lines_on_o,
   output logic      [1:0]  output_strength_o,
   output logic      [7:0]  wrap_cfg_o
);
   import sfcf_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Link domain: serial clock side
   ////////////////////////////////////////////////////////////////////////////
   logic        fst_q;
   logic [15:0] cnt_q;
   logic [15:0] cur_c;
   logic [7:0]  op_q;
   logic [23:0] addr_q;
   logic [7:0]  din_q;
   logic [7:0]  pb_byte_q;
   logic [7:0]  pb_pos_q;
   logic        pb_tog_q;
   logic [23:0] st_a_q;
   logic [23:0] st_b_q;
   logic [3:0]  out_q;
   logic [3:0]  oe_q;
   logic [1:0]  aw;
   logic [1:0]  ows;
   logic        has_addr;
   logic        rd;
   logic        wr_in;
   logic        st_rd;
   logic [15:0] aclk;
   logic [15:0] mclk;
   logic [15:0] dclk;
   logic [15:0] start;
   logic [15:0] in_idx;
   logic [15:0] out_idx;
   logic [15:0] bidx;
   logic [7:0]  obyte;
   logic [7:0]  sh;
   logic [2:0]  pos;
   logic [23:0] st_word;

   // Frame marker: set while deselected, cleared by first edge
   always_ff @(posedge sclk_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         fst_q <= 1'b1;
      end else begin
         fst_q <= 1'b0;
      end
   end

   // Clock index of the current rising edge within the frame
   assign cur_c = fst_q ? 16'h0000 : cnt_q;

   // Counter holds after deselect for the core to read
   always_ff @(posedge sclk_i) begin
      if (cur_c != 16'hFFFF) begin
         cnt_q <= cur_c + 16'h0001;
      end else begin
         cnt_q <= cur_c;
      end
   end

   // Status word crossing; static within a frame
   always_ff @(posedge sclk_i) begin
      st_a_q <= st_word;
      st_b_q <= st_a_q;
   end

   // Phase plan per opcode
   always_comb begin
      aw       = 2'h0;
      ows      = 2'h0;
      has_addr = 1'b0;
      rd       = 1'b0;
      wr_in    = 1'b0;
      st_rd    = 1'b0;
      mclk     = 16'h0000;
      dclk     = 16'h0000;
      case (op_q)
         OP_RD_SR1, OP_RD_SR2, OP_RD_SR3: begin
            rd    = 1'b1;
            st_rd = 1'b1;
         end
         OP_READ: begin
            has_addr = 1'b1;
            rd       = 1'b1;
         end
         OP_FAST: begin
            has_addr = 1'b1;
            rd       = 1'b1;
            dclk     = FAST_DUMMY_CLKS;
         end
         OP_DUAL_OUT: begin
            has_addr = 1'b1;
            rd       = 1'b1;
            dclk     = FAST_DUMMY_CLKS;
            ows      = 2'h1;
         end
         OP_QUAD_OUT: begin
            has_addr = st_b_q[QUAD_BIT];
            rd       = st_b_q[QUAD_BIT];
            dclk     = FAST_DUMMY_CLKS;
            ows      = 2'h2;
         end
         OP_DUAL_IO: begin
            has_addr = 1'b1;
            rd       = 1'b1;
            aw       = 2'h1;
            ows      = 2'h1;
            mclk     = MODE_BITS >> 1;
            dclk     = st_b_q[DSEL_BIT] ? DIO_DUMMY_HI : DIO_DUMMY_LO;
         end
         OP_QUAD_IO: begin
            has_addr = st_b_q[QUAD_BIT];
            rd       = st_b_q[QUAD_BIT];
            aw       = 2'h2;
            ows      = 2'h2;
            mclk     = MODE_BITS >> 2;
            dclk     = st_b_q[DSEL_BIT] ? QIO_DUMMY_HI : QIO_DUMMY_LO;
         end
         OP_WR_SR1, OP_WR_SR2, OP_WR_SR3: begin
            wr_in = 1'b1;
         end
         OP_PROG: begin
            has_addr = 1'b1;
            wr_in    = 1'b1;
         end
         OP_WRAP: begin
            wr_in = 1'b1;
            dclk  = WRAP_DUMMY_CLKS;
         end
         default: begin
            rd = 1'b0;
         end
      endcase
   end

   assign aclk    = has_addr ? (ADDR_BITS >> aw) : 16'h0000;
   assign start   = OPCODE_CLKS + aclk + mclk + dclk;
   assign in_idx  = cur_c - start;
   assign out_idx = cnt_q - start;

   // Opcode shifts in MSB first on IO0
   always_ff @(posedge sclk_i) begin
      if (cur_c < OPCODE_CLKS) begin
         op_q <= {op_q[6:0], io_i[0]};
      end
   end

   // Address on one, two or four lines, high bits first
   always_ff @(posedge sclk_i) begin
      if (has_addr && cur_c >= OPCODE_CLKS && cur_c < OPCODE_CLKS + aclk) begin
         case (aw)
            2'h1:    addr_q <= {addr_q[21:0], io_i[1:0]};
            2'h2:    addr_q <= {addr_q[19:0], io_i[3:0]};
            default: addr_q <= {addr_q[22:0], io_i[0]};
         endcase
      end
   end

   // Input data; program bytes go over singly
   always_ff @(posedge sclk_i) begin
      if (wr_in && cur_c >= OPCODE_CLKS && cur_c >= start) begin
         din_q <= {din_q[6:0], io_i[0]};
         if (op_q == OP_PROG && in_idx[2:0] == 3'h7) begin
            pb_byte_q <= {din_q[6:0], io_i[0]};
            pb_pos_q  <= addr_q[7:0] + in_idx[10:3];
         end
      end
   end

   // Event toggle; its drop at deselect only rewrites the last byte
   always_ff @(posedge sclk_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         pb_tog_q <= 1'b0;
      end else if (wr_in && op_q == OP_PROG && cur_c >= OPCODE_CLKS
                   && cur_c >= start && in_idx[2:0] == 3'h7) begin
         pb_tog_q <= ~pb_tog_q;
      end
   end

   // Output byte source and lane packing
   always_comb begin
      case (op_q)
         OP_RD_SR2: obyte = st_b_q[15:8];
         OP_RD_SR3: obyte = st_b_q[23:16];
         OP_RD_SR1: obyte = st_b_q[7:0];
         default:   obyte = mem_rdata_i;
      endcase
      case (ows)
         2'h1:    pos = {1'b0, out_idx[1:0]} << 1;
         2'h2:    pos = {out_idx[0], 2'h0};
         default: pos = out_idx[2:0];
      endcase
      case (ows)
         2'h1:    bidx = out_idx >> 2;
         2'h2:    bidx = out_idx >> 1;
         default: bidx = out_idx >> 3;
      endcase
      sh = obyte << pos;
   end

   // Byte address streams on from the start address
   assign mem_addr_o = addr_q + bidx[15:0];

   // Drive on the fall; the host samples on the rise
   always_ff @(negedge sclk_i or posedge cs_b_i) begin
      if (cs_b_i) begin
         oe_q  <= 4'h0;
         out_q <= 4'h0;
      end else if (!fst_q && rd && cnt_q >= start && cnt_q >= OPCODE_CLKS) begin
         case (ows)
            2'h1: begin
               oe_q  <= 4'h3;
               out_q <= {2'h0, sh[7:6]};
            end
            2'h2: begin
               oe_q  <= 4'hF;
               out_q <= sh[7:4];
            end
            default: begin
               oe_q  <= 4'h2;
               out_q <= {2'h0, sh[7], 1'b0};
            end
         endcase
      end else begin
         oe_q <= 4'h0;
      end
   end

   // Released on deselect, with no clock edge
   assign io_oe_o = cs_b_i ? 4'h0 : oe_q;
   assign io_o    = out_q & io_oe_o;

   ////////////////////////////////////////////////////////////////////////////
   // Core domain: chip select and byte event crossing
   ////////////////////////////////////////////////////////////////////////////
   logic [2:0] cs_s_q;
   logic       cs_lvl_q;
   logic [2:0] tg_s_q;
   logic       tg_lvl_q;
   logic       end_evt;
   logic       pb_evt;

   // Three-flop synchronisers; stages two and three agree
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         cs_s_q   <= 3'h7;
         cs_lvl_q <= 1'b1;
         tg_s_q   <= 3'h0;
         tg_lvl_q <= 1'b0;
      end else begin
         cs_s_q <= {cs_s_q[1:0], cs_b_i};
         tg_s_q <= {tg_s_q[1:0], pb_tog_q};
         if (cs_s_q[1] == cs_s_q[2]) begin
            cs_lvl_q <= cs_s_q[2];
         end
         if (tg_s_q[1] == tg_s_q[2]) begin
            tg_lvl_q <= tg_s_q[2];
         end
      end
   end

   // Frame end; link registers frozen while deselected
   assign end_evt = (cs_s_q[1] == cs_s_q[2]) && cs_s_q[2] && !cs_lvl_q;
   assign pb_evt  = (tg_s_q[1] == tg_s_q[2]) && (tg_s_q[2] != tg_lvl_q);

   ////////////////////////////////////////////////////////////////////////////
   // Core domain: frame decode and status
   ////////////////////////////////////////////////////////////////////////////
   logic       wel_q;
   logic       vol_wen_q;
   logic       rst_arm_q;
   logic [1:0] srp_q;
   logic [4:0] bp_q;
   logic [2:0] lock_q;
   logic       inv_q;
   logic       epause_q;
   logic       ppause_q;
   logic       quad_q;
   logic       dsel_q;
   logic [1:0] drv_q;
   logic [7:0] wrap_q;
   logic       whole;
   logic       one_b;
   logic       two_b;
   logic       sw_ok;
   logic       sw_hit;
   logic       soft_rst;
   logic [15:0] plen;
   logic [7:0] pbuf_q [256];

   assign whole    = end_evt && cnt_q[2:0] == 3'h0 && cnt_q != 16'h0000;
   assign one_b    = whole && cnt_q == ONE_BYTE_CLKS;
   assign two_b    = whole && cnt_q == TWO_BYTE_CLKS;
   assign sw_ok    = vol_wen_q || (wel_q && !busy_i);
   assign sw_hit   = two_b && sw_ok && (op_q == OP_WR_SR1 || op_q == OP_WR_SR2
                     || op_q == OP_WR_SR3);
   assign soft_rst = one_b && op_q == OP_RST_DO && rst_arm_q;
   assign plen     = (cnt_q - PROG_HDR_CLKS) >> 3;

   // Write-enable latch; a set in the same cycle as a completion wins
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wel_q <= 1'b0;
      end else begin
         if (done_i || soft_rst) begin
            wel_q <= 1'b0;
         end
         if (one_b && op_q == OP_WR_DISABLE && !busy_i) begin
            wel_q <= 1'b0;
         end
         if (one_b && op_q == OP_WR_ENABLE) begin
            wel_q <= 1'b1;
         end
      end
   end

   // Volatile write enable and reset arm
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         vol_wen_q <= 1'b0;
         rst_arm_q <= 1'b0;
      end else if (end_evt) begin
         rst_arm_q <= one_b && op_q == OP_RST_ARM;
         if (sw_hit || soft_rst) begin
            vol_wen_q <= 1'b0;
         end else if (one_b && op_q == OP_VOL_SR_EN) begin
            vol_wen_q <= 1'b1;
         end
      end
   end

   // Writable status fields; reserved bits not stored
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         srp_q  <= 2'h0;
         bp_q   <= BP_RST;
         lock_q <= LOCK_RST;
         inv_q  <= 1'b0;
         quad_q <= 1'b0;
         dsel_q <= 1'b0;
         drv_q  <= STRENGTH_RST;
      end else if (sw_hit) begin
         case (op_q)
            OP_WR_SR1: begin
               srp_q[0] <= din_q[7];
               bp_q     <= din_q[6:2];
            end
            OP_WR_SR2: begin
               srp_q[1] <= din_q[0];
               quad_q   <= din_q[1];
               lock_q   <= lock_q | din_q[5:3];
               inv_q    <= din_q[6];
            end
            default: begin
               drv_q  <= din_q[6:5];
               dsel_q <= din_q[0];
            end
         endcase
      end
   end

   // Paused flags, read only to the host
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         epause_q <= 1'b0;
         ppause_q <= 1'b0;
      end else if (soft_rst || (one_b && op_q == OP_RESUME)) begin
         epause_q <= 1'b0;
         ppause_q <= 1'b0;
      end else if (one_b && op_q == OP_SUSPEND && busy_i) begin
         if (erase_active_i) begin
            epause_q <= 1'b1;
         end else begin
            ppause_q <= 1'b1;
         end
      end
   end

   // Wrap configuration byte
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         wrap_q <= 8'h00;
      end else if (whole && op_q == OP_WRAP && cnt_q == WRAP_CLKS) begin
         wrap_q <= din_q;
      end
   end

   // Engine requests; a torn byte drops the program
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         prog_req_o      <= 1'b0;
         status_wr_req_o <= 1'b0;
         prog_addr_o     <= 24'h000000;
         prog_len_o      <= 9'h000;
      end else begin
         prog_req_o      <= 1'b0;
         status_wr_req_o <= sw_hit && !vol_wen_q;
         if (whole && op_q == OP_PROG && cnt_q >= PROG_MIN_CLKS
             && wel_q && !busy_i) begin
            prog_req_o  <= 1'b1;
            prog_addr_o <= addr_q;
            prog_len_o  <= (plen > PAGE_BYTES) ? 9'h100 : plen[8:0];
         end
      end
   end

   // Page buffer, read back by the engine
   always_ff @(posedge clk_i) begin
      if (pb_evt && !cs_lvl_q) begin
         pbuf_q[pb_pos_q] <= pb_byte_q;
      end
      buf_rd_data_o <= pbuf_q[buf_rd_idx_i];
   end

   // Status word; busy comes from the engine
   assign st_word = {1'b0, drv_q, 4'h0, dsel_q,
                     epause_q, inv_q, lock_q, ppause_q, quad_q, srp_q[1],
                     srp_q[0], bp_q, wel_q, busy_i};

   assign block_protect_field_o = bp_q;
   assign protect_invert_o      = inv_q;
   assign otp_lock_o            = lock_q;
   assign quad_lines_on_o       = quad_q;
   assign output_strength_o     = drv_q;
   assign wrap_cfg_o            = wrap_q;
endmodule
`default_nettype wire

// ===== bench/sfcf_frontend_sva.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_frontend_sva (
   input wire logic       clk_i,
   input wire logic       rst_b_i,
   input wire logic       cs_b_i,
   input wire logic [3:0] io_oe_o,
   input wire logic       prog_req_o,
   input wire logic [8:0] prog_len_o,
   input wire logic       status_wr_req_o,
   input wire logic [2:0] otp_lock_o,
   input wire logic       protect_invert_o,
   input wire logic       quad_lines_on_o,
   input wire logic [1:0] output_strength_o,
   input wire logic [7:0] wrap_cfg_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_b_i);
   // Select high on three edges
   sequence closed_s;
      $past(cs_b_i, 2) && $past(cs_b_i) && cs_b_i;
   endsequence
   sequence pulse_s(logic s);
      s ##1 !s;
   endsequence
   // Core outputs
   a_oe_desel_off: assert property (cs_b_i |-> io_oe_o == 4'h0)
      else $error("lines driven while deselected");
   a_quad_needs_qe: assert property (io_oe_o == 4'hF |-> quad_lines_on_o)
      else $error("four lanes driven with quad off");
   a_prog_after_frame: assert property (prog_req_o |-> closed_s ##0 pulse_s(prog_req_o))
      else $error("program commit inside a frame");
   a_prog_len_range: assert property (prog_req_o |-> prog_len_o inside {[9'h001:9'h100]})
      else $error("program length out of range");
   a_stwr_after_frame: assert property (status_wr_req_o |-> closed_s ##0 pulse_s(status_wr_req_o))
      else $error("bad status write pulse");
   a_lock_only_sets: assert property (($past(otp_lock_o) & ~otp_lock_o) == 3'h0)
      else $error("lock bit cleared");
   a_cfg_after_frame: assert property ($changed({protect_invert_o, otp_lock_o,
      quad_lines_on_o, output_strength_o, wrap_cfg_o}) |-> closed_s)
      else $error("config moved in a frame");
   a_reset_defaults: assert property ($rose(rst_b_i) |-> output_strength_o == 2'h1
      && otp_lock_o == 3'h0 && !protect_invert_o && !quad_lines_on_o && wrap_cfg_o == 8'h00)
      else $error("wrong value after reset");
endmodule
bind sfcf_frontend sfcf_frontend_sva u_sva (.*);
`default_nettype wire

// ===== bench/sfcf_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_host_model (
   output logic            sclk_o,
   output logic            cs_b_o,
   output logic      [3:0] io_o,
   input  wire logic [3:0] io_i
);
   // Idle: deselected, clock parked
   initial begin
      sclk_o = 1'b0;
      cs_b_o = 1'b1;
      io_o = 4'h0;
   end
   // n clocks on w lanes; idle lanes toggle
   task automatic bits(input logic [31:0] d, input int n, input int w, input bit drv,
                       output logic [31:0] r);
      logic [3:0] v;
      r = 32'h0;
      cs_b_o = 1'b0;
      for (int i = 0; i < n; i++) begin
         v = ~io_o;
         for (int j = 0; j < w; j++)
            if (drv)
               v[j] = d[w * (n - 1 - i) + j];
         io_o = v;
         #62.5 sclk_o = 1'b1;
         for (int j = w - 1; j >= 0; j--)
            r = {r[30:0], io_i[(w == 1) ? 1 : j]};
         #62.5 sclk_o = 1'b0;
      end
   endtask
   // Deselect, give the core time
   task automatic close();
      #20 cs_b_o = 1'b1;
      #300;
   endtask
   task automatic cmd(input logic [7:0] op);
      logic [31:0] r;
      bits({24'h0, op}, 8, 1, 1'b1, r);
      close();
   endtask
endmodule
`default_nettype wire

// ===== bench/sfcf_frontend_tb.sv
`timescale 1ns/1ps
`default_nettype none
module sfcf_frontend_tb;
   import sfcf_pkg::*;
   logic        clk_i, rst_b_i, busy_i, done_i, erase_active_i;
   logic [7:0]  buf_rd_idx_i;
   wire  logic  sclk, cs_b, prog_req_o, status_wr_req_o, protect_invert_o, quad_lines_on_o;
   wire  logic [3:0]  h_io, io_w, io_o, io_oe_o;
   wire  logic [23:0] mem_addr_o, prog_addr_o;
   wire  logic [8:0]  prog_len_o;
   wire  logic [7:0]  mem_rdata_i, buf_rd_data_o, wrap_cfg_o;
   wire  logic [4:0]  block_protect_field_o;
   wire  logic [2:0]  otp_lock_o;
   wire  logic [1:0]  output_strength_o;
   int          fail_count = 0, n_tests = 0, pg_n = 0, sw_n = 0, cyc = 0;
   logic [31:0] pg_a, pg_l;
   ////////////////////////////////////////
   // Merged lines; data follows address
   assign io_w = (io_oe_o & io_o) | (~io_oe_o & h_io);
   assign mem_rdata_i = mem_addr_o[7:0] ^ 8'h5A;
   sfcf_host_model u_host (.sclk_o(sclk), .cs_b_o(cs_b), .io_o(h_io), .io_i(io_w));
   sfcf_frontend uut (.clk_i, .rst_b_i, .sclk_i(sclk), .cs_b_i(cs_b), .io_i(io_w), .io_o,
      .io_oe_o, .mem_addr_o, .mem_rdata_i, .busy_i, .done_i, .erase_active_i, .prog_req_o,
      .prog_addr_o, .prog_len_o, .buf_rd_idx_i, .buf_rd_data_o, .status_wr_req_o,
      .block_protect_field_o, .protect_invert_o, .otp_lock_o, .quad_lines_on_o,
      .output_strength_o, .wrap_cfg_o);
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Commit watcher and hang guard
   always @(posedge clk_i) begin
      cyc++;
      if (prog_req_o === 1'b1) begin
         pg_n++;
         pg_a = prog_addr_o;
         pg_l = prog_len_o;
      end
      if (status_wr_req_o === 1'b1)
         sw_n++;
      if (cyc == 60000) begin
         fail_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   // Two bytes, so a byte that fails to repeat shows
   task automatic sr_is(input logic [7:0] op, input logic [7:0] e);
      logic [31:0] r;
      u_host.bits({24'h0, op}, 8, 1, 1'b1, r);
      u_host.bits(32'h0, 16, 1, 1'b0, r);
      u_host.close();
      chk("status", r, {16'h0, e, e});
   endtask
   task automatic wr2(input logic [7:0] op, input logic [7:0] v);
      logic [31:0] r;
      u_host.bits({16'h0, op, v}, 16, 1, 1'b1, r);
      u_host.close();
   endtask
   task automatic done_pulse();
      @(negedge clk_i) done_i = 1'b1;
      @(negedge clk_i) done_i = 1'b0;
   endtask
   // Defaults, latch, torn frame, locks
   task automatic t_stwr();
      int          n0;
      logic [31:0] r;
      sr_is(OP_RD_SR1, 8'h00);
      sr_is(OP_RD_SR3, 8'h20);
      chk("drv", output_strength_o, 2'h1);
      wr2(OP_WR_SR2, 8'h4A);
      sr_is(OP_RD_SR2, 8'h00);
      u_host.cmd(OP_WR_ENABLE);
      sr_is(OP_RD_SR1, 8'h02);
      n0 = sw_n;
      u_host.bits({OP_WR_SR2, 8'h4A} >> 1, 15, 1, 1'b1, r);
      u_host.close();
      wr2(OP_WR_SR2, 8'h4A);
      chk("stwr req", sw_n - n0, 1);
      sr_is(OP_RD_SR2, 8'h4A);
      chk("lock", otp_lock_o, 3'h1);
      chk("invert", protect_invert_o, 1'b1);
      chk("quad", quad_lines_on_o, 1'b1);
      done_pulse();
      sr_is(OP_RD_SR1, 8'h00);
      u_host.cmd(OP_WR_ENABLE);
      wr2(OP_WR_SR2, 8'h02);
      done_pulse();
      sr_is(OP_RD_SR2, 8'h0A);
      u_host.cmd(OP_WR_ENABLE);
      u_host.cmd(OP_WR_DISABLE);
      sr_is(OP_RD_SR1, 8'h00);
      $display("stwr end");
   endtask
   // Output reads across a byte boundary
   task automatic t_read();
      logic [7:0]  ops [4] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_QUAD_OUT};
      int          dm  [4] = '{0, 8, 8, 8};
      int          ln  [4] = '{1, 1, 2, 4};
      logic [31:0] r;
      for (int k = 0; k < 4; k++) begin
         u_host.bits({ops[k], 24'h1234FE}, 32, 1, 1'b1, r);
         if (dm[k] > 0)
            u_host.bits(32'h0, dm[k], 1, 1'b0, r);
         u_host.bits(32'h0, 16 / ln[k], ln[k], 1'b0, r);
         u_host.close();
         chk("read", r, 32'hA4A5);
      end
      $display("read end");
   endtask
   // I/O reads, both dummy settings
   task automatic t_dio();
      int          n0;
      logic [31:0] r;
      for (int dc = 0; dc < 2; dc++) begin
         n0 = sw_n;
         u_host.cmd(OP_VOL_SR_EN);
         wr2(OP_WR_SR3, 8'h20 | 8'(dc));
         chk("vol req", sw_n - n0, 0);
         u_host.bits({24'h0, OP_DUAL_IO}, 8, 1, 1'b1, r);
         u_host.bits(32'h1234FE00, 16, 2, 1'b1, r);
         u_host.bits(32'h0, 4 + 4 * dc, 2, 1'b0, r);
         u_host.bits(32'h0, 8, 2, 1'b0, r);
         u_host.close();
         chk("dual io", r, 32'hA4A5);
         u_host.bits({24'h0, OP_QUAD_IO}, 8, 1, 1'b1, r);
         u_host.bits(32'h1234FE00, 8, 4, 1'b1, r);
         u_host.bits(32'h0, 6 + 4 * dc, 4, 1'b0, r);
         u_host.bits(32'h0, 4, 4, 1'b0, r);
         u_host.close();
         chk("quad io", r, 32'hA4A5);
      end
      $display("dio end");
   endtask
   // Torn frame dropped; whole one wraps in page
   task automatic t_prog();
      int          n0;
      logic [31:0] r;
      u_host.cmd(OP_WR_ENABLE);
      n0 = pg_n;
      u_host.bits({OP_PROG, 24'h0001FF}, 32, 1, 1'b1, r);
      u_host.bits(32'h52D, 11, 1, 1'b1, r);
      u_host.close();
      chk("part prog", pg_n - n0, 0);
      sr_is(OP_RD_SR1, 8'h02);
      u_host.bits({OP_PROG, 24'h0001FF}, 32, 1, 1'b1, r);
      u_host.bits(32'hA53C, 16, 1, 1'b1, r);
      u_host.close();
      chk("prog req", pg_n - n0, 1);
      chk("prog addr", pg_a, 32'h1FF);
      chk("prog len", pg_l, 32'h2);
      @(negedge clk_i) buf_rd_idx_i = 8'hFF;
      @(negedge clk_i) buf_rd_idx_i = 8'h00;
      chk("buf ff", buf_rd_data_o, 8'hA5);
      @(negedge clk_i);
      chk("buf 00", buf_rd_data_o, 8'h3C);
      done_pulse();
      sr_is(OP_RD_SR1, 8'h00);
      $display("prog end");
   endtask
   // Pause flags: suspend, resume, reset pair
   task automatic t_susp();
      @(negedge clk_i) busy_i = 1'b1;
      erase_active_i = 1'b1;
      sr_is(OP_RD_SR1, 8'h01);
      u_host.cmd(OP_SUSPEND);
      sr_is(OP_RD_SR2, 8'h8A);
      u_host.cmd(OP_RESUME);
      sr_is(OP_RD_SR2, 8'h0A);
      @(negedge clk_i) erase_active_i = 1'b0;
      u_host.cmd(OP_SUSPEND);
      sr_is(OP_RD_SR2, 8'h0E);
      u_host.cmd(OP_RST_ARM);
      u_host.cmd(OP_RST_DO);
      sr_is(OP_RD_SR2, 8'h0A);
      @(negedge clk_i) busy_i = 1'b0;
      $display("susp end");
   endtask
   // Wrap byte; unknown opcode inert; block protect write
   task automatic t_wrap();
      logic [31:0] r;
      u_host.bits({OP_WRAP, 24'h0}, 32, 1, 1'b1, r);
      u_host.bits(32'h40, 8, 1, 1'b1, r);
      u_host.close();
      chk("wrap", wrap_cfg_o, 8'h40);
      u_host.bits({16'h0, 8'hFF, OP_WR_SR2}, 16, 1, 1'b1, r);
      u_host.close();
      sr_is(OP_RD_SR2, 8'h0A);
      chk("wrap kept", wrap_cfg_o, 8'h40);
      u_host.cmd(OP_WR_ENABLE);
      wr2(OP_WR_SR1, 8'h1C);
      chk("bp", block_protect_field_o, 5'h07);
      $display("wrap end");
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      rst_b_i = 1'b0;
      busy_i = 1'b0;
      done_i = 1'b0;
      erase_active_i = 1'b0;
      buf_rd_idx_i = 8'h00;
      repeat (4) @(posedge clk_i);
      @(negedge clk_i) rst_b_i = 1'b1;
      t_stwr();
      t_read();
      t_dio();
      t_prog();
      t_susp();
      t_wrap();
      finish_test();
   end
endmodule
`default_nettype wire
